// ### core/dee_ctrl.sv
// data eeprom erase and write control with avalon-mm register slave
// Operation
// [RULE1] page mode erase acts on a sixteen byte page held in a buffer
// [RULE2] page buffer is cleared by power-on reset
// [RULE3] erase enable falling clears page buffer, rising leaves it
// [RULE4] page mode data writes bump low four address bits, never the upper three
// [RULE5] the low address nibble saturates at F, no wrap
// [RULE6] each data write tags its address for erase, value ignored; code tags only page mode writes, up to and including the one at F
// [RULE7] firmware sets erase enable then erase start on the next instruction
// [RULE8] firmware masks global interrupts around the activation sequence
// [RULE9] erase cycle timed by asynchronous timer, end clears erase start
// [RULE10] erase completion clears erase enable
// [RULE11] erased page locations read back as zero
// [RULE12] byte write: load address and data, enable then start next cycle
// [RULE13] write start ignored unless write enable already set
// [RULE14] write cycle end clears write start for polling
// [RULE15] byte write erases the target byte first, then programs it
// [RULE16] page mode write enable falling clears buffer, rising does not
// [RULE17] page mode data writes load buffer and advance nibble, sixteen bytes
// [RULE18] data writes after nibble reached F are discarded
// [RULE19] write completion clears write enable
// [RULE20] firmware erases the page before a page write
// [RULE21] cycle end sets done flag and multi-function flag; service clears latter
// [RULE22] firmware must not sleep until the operation completes
// [RULE23] erase start ignored unless erase enable already set
// [RULE24] seven bit address: three page bits, four byte pointer bits
// [RULE25] timer completion is synchronised before it acts
//
// Decided for this implementation: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module dee_ctrl (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	input wire logic i_timer_done,
	input wire logic i_mf_service,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_timer_run,
	output logic o_nvm_irq,
	output logic o_mf_flag
);

	// ****************************************************************
	// declarations
	// ****************************************************************
	localparam int PAGE_BYTES_L = dee_pkg::PAGE_BYTES;

	logic wait_q;
	logic [31:0] rdata_q;
	logic [6:0] nvm_address_reg_q;
	logic [7:0] nvm_data_reg_q;
	logic erase_enable_bit_q, erase_enable_bit_d;
	logic erase_start_q, erase_start_d;
	logic mode_q;
	logic write_enable_bit_q, write_enable_bit_d;
	logic write_start_q, write_start_d;
	logic nvm_done_flag_q, nvm_irq_enable_q, mf_flag_q, irq_q, run_q;
	logic full_q;
	logic [7:0] page_buf_q [PAGE_BYTES_L];
	logic [15:0] tag_q;
	logic [7:0] mem [128];
	logic done_s1_q, done_s2_q, done_s3_q;
	dee_pkg::dee_state_t state_q, state_d;
	logic wr_acc, idle, ctl_wr, dat_wr, adr_wr, start_erase, start_write;
	logic done_pulse, fin, buf_clear;
	logic [3:0] nib;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction : hit

	// ****************************************************************
	// bus slave: one wait cycle, then the transfer completes
	// ****************************************************************
	assign o_waitrequest = wait_q;
	assign o_readdata = rdata_q;
	assign wr_acc = i_write && !wait_q && i_byteenable[0];
	assign idle = (state_q == dee_pkg::DEE_IDLE);
	assign ctl_wr = wr_acc && hit(i_address, dee_pkg::OFF_CTRL) && idle;
	assign dat_wr = wr_acc && hit(i_address, dee_pkg::OFF_DATA) && idle;
	assign adr_wr = wr_acc && hit(i_address, dee_pkg::OFF_ADDR) && idle;
	assign nib = nvm_address_reg_q[3:0];

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wait_q <= 1'b1;
		end else if (i_ce) begin
			wait_q <= !((i_read || i_write) && wait_q);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_q <= dee_pkg::RD_UNMAPPED;
		end else if (i_ce && i_read && wait_q) begin
			unique case (i_address)
				dee_pkg::OFF_ADDR: rdata_q <= {25'h0000000, nvm_address_reg_q};
				dee_pkg::OFF_DATA: rdata_q <= {24'h000000, nvm_data_reg_q};
				dee_pkg::OFF_CTRL: rdata_q <= {25'h0000000, erase_enable_bit_q,
					erase_start_q, mode_q, write_enable_bit_q, write_start_q, 2'b00};
				dee_pkg::OFF_DONE: rdata_q <= {29'h00000000, mf_flag_q,
					nvm_irq_enable_q, nvm_done_flag_q};
				dee_pkg::OFF_PEEK: rdata_q <= {24'h000000, mem[nvm_address_reg_q]}; // RULE11
				default: rdata_q <= dee_pkg::RD_UNMAPPED;
			endcase
		end
	end

	// ****************************************************************
	// timer completion synchroniser
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end else if (i_ce) begin
			done_s1_q <= i_timer_done; // RULE25
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end

	assign done_pulse = done_s2_q && !done_s3_q; // RULE25
	assign fin = done_pulse && (state_q == dee_pkg::DEE_PROG || state_q == dee_pkg::DEE_PERASE);

	// ****************************************************************
	// control register next values
	// ****************************************************************
	assign start_erase = ctl_wr && i_writedata[dee_pkg::B_ERASE_GO] && erase_enable_bit_q
		&& mode_q; // RULE23
	assign start_write = ctl_wr && i_writedata[dee_pkg::B_WRITE_GO] && write_enable_bit_q; // RULE13

	always_comb begin
		erase_enable_bit_d = erase_enable_bit_q;
		erase_start_d = erase_start_q;
		write_enable_bit_d = write_enable_bit_q;
		write_start_d = write_start_q;
		if (fin && state_q == dee_pkg::DEE_PERASE) begin
			erase_start_d = 1'b0; // RULE9
			erase_enable_bit_d = 1'b0; // RULE10
		end else if (fin) begin
			write_start_d = 1'b0; // RULE14
			write_enable_bit_d = 1'b0; // RULE19
		end else if (ctl_wr) begin
			erase_enable_bit_d = i_writedata[dee_pkg::B_ERASE_EN];
			write_enable_bit_d = i_writedata[dee_pkg::B_WRITE_EN];
			erase_start_d = start_erase;
			write_start_d = start_write;
		end
	end

	assign buf_clear = (erase_enable_bit_q && !erase_enable_bit_d) // RULE3
		|| (mode_q && write_enable_bit_q && !write_enable_bit_d); // RULE16

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			erase_enable_bit_q <= 1'b0;
			erase_start_q <= 1'b0;
			write_enable_bit_q <= 1'b0;
			write_start_q <= 1'b0;
			mode_q <= 1'b0;
		end else if (i_ce) begin
			erase_enable_bit_q <= erase_enable_bit_d;
			erase_start_q <= erase_start_d;
			write_enable_bit_q <= write_enable_bit_d;
			write_start_q <= write_start_d;
			if (ctl_wr) begin
				mode_q <= i_writedata[dee_pkg::B_MODE];
			end
		end
	end

	// ****************************************************************
	// address and data registers, page pointer
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			nvm_address_reg_q <= dee_pkg::RST_ADDR;
			nvm_data_reg_q <= dee_pkg::RST_DATA;
			full_q <= 1'b0;
		end else if (i_ce) begin
			if (adr_wr) begin
				nvm_address_reg_q <= i_writedata[6:0];
				full_q <= 1'b0;
			end else if (dat_wr) begin
				nvm_data_reg_q <= i_writedata[7:0];
				if (mode_q && !full_q) begin
					if (nib == dee_pkg::NIB_LAST) begin
						full_q <= 1'b1; // RULE5
					end else begin
						nvm_address_reg_q[3:0] <= nib + 4'h1; // RULE4 RULE24
					end
				end
			end else if (buf_clear) begin
				full_q <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// page buffer and address tags
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tag_q <= 16'h0000; // RULE2
			for (int i = 0; i < PAGE_BYTES_L; i++) begin
				page_buf_q[i] <= dee_pkg::RST_DATA;
			end
		end else if (i_ce) begin
			if (buf_clear) begin
				tag_q <= 16'h0000; // RULE3 RULE16
				for (int i = 0; i < PAGE_BYTES_L; i++) begin
					page_buf_q[i] <= dee_pkg::RST_DATA;
				end
			end else if (dat_wr && mode_q && !full_q) begin
				tag_q[nib] <= 1'b1; // RULE6
				page_buf_q[nib] <= i_writedata[7:0]; // RULE17 RULE18
			end
		end
	end

	// ****************************************************************
	// cycle sequencer
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			dee_pkg::DEE_IDLE: begin
				if (start_erase) begin
					state_d = dee_pkg::DEE_PERASE;
				end else if (start_write && !mode_q) begin
					state_d = dee_pkg::DEE_BERASE; // RULE15
				end else if (start_write) begin
					state_d = dee_pkg::DEE_PROG;
				end
			end
			dee_pkg::DEE_BERASE: state_d = dee_pkg::DEE_PROG;
			dee_pkg::DEE_PROG, dee_pkg::DEE_PERASE: begin
				if (done_pulse) begin
					state_d = dee_pkg::DEE_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= dee_pkg::DEE_IDLE;
			run_q <= 1'b0;
		end else if (i_ce) begin
			state_q <= state_d;
			run_q <= (state_d == dee_pkg::DEE_PROG) || (state_d == dee_pkg::DEE_PERASE); // RULE9
		end
	end

	assign o_timer_run = run_q;

	// ****************************************************************
	// array
	// ****************************************************************
	always_ff @(posedge i_mclk) begin
		if (i_ce) begin
			if (state_q == dee_pkg::DEE_BERASE) begin
				mem[nvm_address_reg_q] <= dee_pkg::ERASED_BYTE; // RULE15
			end else if (fin && state_q == dee_pkg::DEE_PERASE) begin
				for (int i = 0; i < PAGE_BYTES_L; i++) begin
					if (tag_q[i]) begin
						mem[{nvm_address_reg_q[6:4], 4'(i)}] <= dee_pkg::ERASED_BYTE; // RULE1 RULE11
					end
				end
			end else if (fin && !mode_q) begin
				mem[nvm_address_reg_q] <= nvm_data_reg_q;
			end else if (fin) begin
				for (int i = 0; i < PAGE_BYTES_L; i++) begin
					if (tag_q[i]) begin
						mem[{nvm_address_reg_q[6:4], 4'(i)}] <= page_buf_q[i]; // RULE17
					end
				end
			end
		end
	end

	// ****************************************************************
	// completion flags
	// ****************************************************************
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			nvm_done_flag_q <= 1'b0;
			nvm_irq_enable_q <= 1'b0;
			mf_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else if (i_ce) begin
			if (fin) begin
				nvm_done_flag_q <= 1'b1; // RULE21
			end else if (wr_acc && hit(i_address, dee_pkg::OFF_DONE)
				&& !i_writedata[dee_pkg::B_DONE_FLAG]) begin
				nvm_done_flag_q <= 1'b0;
			end
			if (wr_acc && hit(i_address, dee_pkg::OFF_DONE)) begin
				nvm_irq_enable_q <= i_writedata[dee_pkg::B_IRQ_EN];
			end
			if (fin) begin
				mf_flag_q <= 1'b1; // RULE21
			end else if (i_mf_service) begin
				mf_flag_q <= 1'b0;
			end
			irq_q <= nvm_done_flag_q && nvm_irq_enable_q;
		end
	end

	assign o_mf_flag = mf_flag_q;
	assign o_nvm_irq = irq_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	a_erase_start_gate: assert property (i_ce && ctl_wr && !erase_enable_bit_q |=> !erase_start_q) // RULE23
		else $error("erase start taken without enable");
	a_write_start_gate: assert property (i_ce && ctl_wr && !write_enable_bit_q |=> !write_start_q) // RULE13
		else $error("write start taken without enable");
	a_erase_end_clear: assert property (i_ce && fin && state_q == dee_pkg::DEE_PERASE
		|=> !erase_start_q && !erase_enable_bit_q) // RULE9
		else $error("erase end left start or enable set");
	a_write_end_clear: assert property (i_ce && fin && state_q == dee_pkg::DEE_PROG
		|=> !write_start_q && !write_enable_bit_q) // RULE14
		else $error("write end left start or enable set");
	a_done_flags_set: assert property (i_ce && fin |=> nvm_done_flag_q && mf_flag_q) // RULE21
		else $error("completion flags not set");
	a_nib_saturate: assert property (i_ce && dat_wr && mode_q && nib == dee_pkg::NIB_LAST
		|=> nib == dee_pkg::NIB_LAST && full_q) // RULE5
		else $error("page nibble wrapped");
	a_nib_advance: assert property (i_ce && dat_wr && mode_q && !full_q && nib != dee_pkg::NIB_LAST
		|=> nib == $past(nib) + 4'h1 && nvm_address_reg_q[6:4] == $past(nvm_address_reg_q[6:4])) // RULE4
		else $error("page nibble did not advance");
	a_een_fall_clear: assert property (i_ce && $fell(erase_enable_bit_q) |-> tag_q == 16'h0000) // RULE3
		else $error("buffer kept after erase enable fell");
	a_full_discard: assert property (i_ce && dat_wr && full_q |=> $stable(tag_q)) // RULE18
		else $error("data accepted past page end");
	a_sync_done: assert property (fin |-> $past(i_timer_done, 2) && !$past(i_timer_done, 3)) // RULE25
		else $error("completion not synchronised");
	a_berase_first: assert property (i_ce && state_q == dee_pkg::DEE_BERASE
		|=> state_q == dee_pkg::DEE_PROG && run_q) // RULE15
		else $error("byte erase not followed by program");

	c_page_erase: cover property (fin && state_q == dee_pkg::DEE_PERASE);
	c_byte_write: cover property (fin && state_q == dee_pkg::DEE_PROG && !mode_q);
	c_page_write: cover property (fin && state_q == dee_pkg::DEE_PROG && mode_q);
	c_page_full: cover property (dat_wr && full_q);

endmodule : dee_ctrl

`default_nettype wire

// ### shared/dee_pkg.sv
// constants of the data eeprom erase and write control block
`default_nettype none
package dee_pkg;

	// ****************************************************************
	// bus map (byte addresses)
	// ****************************************************************
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_ADDR = 5'h00;
	localparam logic [4:0] OFF_DATA = 5'h04;
	localparam logic [4:0] OFF_CTRL = 5'h08;
	localparam logic [4:0] OFF_DONE = 5'h0C;
	localparam logic [4:0] OFF_PEEK = 5'h10;

	// ****************************************************************
	// control register fields
	// ****************************************************************
	localparam int B_ERASE_EN = 6;
	localparam int B_ERASE_GO = 5;
	localparam int B_MODE = 4;
	localparam int B_WRITE_EN = 3;
	localparam int B_WRITE_GO = 2;

	// ****************************************************************
	// done register fields
	// ****************************************************************
	localparam int B_DONE_FLAG = 0;
	localparam int B_IRQ_EN = 1;
	localparam int B_MF_FLAG = 2;

	// ****************************************************************
	// geometry and reset values
	// ****************************************************************
	localparam int NVM_AW = 7;
	localparam int PAGE_BYTES = 16;
	localparam logic [3:0] NIB_LAST = 4'hF;
	localparam logic [6:0] RST_ADDR = 7'h00;
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'h00;
	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

	typedef enum logic [1:0] {
		DEE_IDLE = 2'b00,
		DEE_BERASE = 2'b01,
		DEE_PROG = 2'b10,
		DEE_PERASE = 2'b11
	} dee_state_t;

endpackage : dee_pkg

`default_nettype wire

// ### bench/dee_timer_model.sv
// behavioural asynchronous erase and write timer
`timescale 1ns/1ps
`default_nettype none

module dee_timer_model (
	input wire logic i_run,
	input wire logic i_slow,
	output logic o_done
);
	initial o_done = 1'b0;

	// ****************************************************************
	// timed cycle, unrelated to the system clock
	// ****************************************************************
	always @(posedge i_run) begin
		#(i_slow ? 2130 : 170);
		if (i_run === 1'b1) begin
			o_done <= 1'b1;
		end
	end

	// done drops only after run has fallen
	always @(negedge i_run) begin
		#7 o_done <= 1'b0;
	end
endmodule : dee_timer_model

`default_nettype wire

// ### bench/dee_ctrl_test.sv
// self-checking bench of the eeprom erase and write control
`timescale 1ns/1ps
`default_nettype none

module dee_ctrl_test;
	logic i_mclk, i_rstn, i_ce, i_read, i_write, i_mf_service, slow;
	logic global_irq_enable;
	logic [4:0] i_address;
	logic [3:0] i_byteenable;
	logic [31:0] i_writedata, o_readdata;
	logic o_waitrequest, o_timer_run, o_nvm_irq, o_mf_flag;
	wire logic tdone;
	int n_fail, checked, cycles;

	dee_ctrl u_dee_ctrl (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_byteenable(i_byteenable), .i_writedata(i_writedata), .i_timer_done(tdone),
		.i_mf_service(i_mf_service), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .o_timer_run(o_timer_run), .o_nvm_irq(o_nvm_irq),
		.o_mf_flag(o_mf_flag));
	dee_timer_model u_dee_timer_model (.i_run(o_timer_run), .i_slow(slow), .o_done(tdone));

	always #20 i_mclk = ~i_mclk;

	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic rd, input logic [4:0] a, input logic [7:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		i_address <= a;
		i_writedata <= {24'h00_0000, d};
		i_read <= rd;
		i_write <= ~rd;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (n >= 50) chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
		@(posedge i_mclk);
	endtask : bus

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask : wr

	task automatic rc(input string nm, input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b1, a, 8'h00, q);
		chk(nm, e, q);
	endtask : rc

	// enable then start on the very next request
	task automatic launch(input logic [7:0] en, input logic [7:0] go);
		global_irq_enable = 1'b0;
		wr(dee_pkg::OFF_CTRL, en);
		wr(dee_pkg::OFF_CTRL, en | go);
		global_irq_enable = 1'b1;
	endtask : launch

	task automatic wait_done();
		int n;
		logic [31:0] c;
		n = 0;
		c = 32'h0000_0024;
		while ((c & 32'h0000_0024) !== 32'h0000_0000 && n < 300) begin
			bus(1'b1, dee_pkg::OFF_CTRL, 8'h00, c);
			n++;
		end
		if (n >= 300) chk("cycle end", 32'h0000_0000, c);
	endtask : wait_done

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic t_reset();
		rc("ctrl", dee_pkg::OFF_CTRL, 32'h0000_0000);
		rc("addr", dee_pkg::OFF_ADDR, 32'h0000_0000);
		rc("done", dee_pkg::OFF_DONE, 32'h0000_0000);
		wr(5'h14, 8'hFF);
		rc("unmapped", 5'h14, dee_pkg::RD_UNMAPPED);
		chk("mf", 32'h0000_0000, {31'h0, o_mf_flag});
		$display("test reset finished");
	endtask : t_reset

	task automatic t_refuse();
		wr(dee_pkg::OFF_CTRL, 8'h04);
		rc("ctrl wstart", dee_pkg::OFF_CTRL, 32'h0000_0000);
		wr(dee_pkg::OFF_CTRL, 8'h30);
		rc("ctrl estart", dee_pkg::OFF_CTRL, 32'h0000_0010);
		chk("run", 32'h0000_0000, {31'h0, o_timer_run});
		wr(dee_pkg::OFF_CTRL, 8'h00);
		$display("test refuse finished");
	endtask : t_refuse

	task automatic t_byte();
		int n;
		slow = 1'b1;
		wr(dee_pkg::OFF_DONE, 8'h02);
		wr(dee_pkg::OFF_ADDR, 8'h35);
		wr(dee_pkg::OFF_DATA, 8'hA5);
		launch(8'h08, 8'h04);
		n = 0;
		while (o_timer_run !== 1'b1 && n < 20) begin
			@(posedge i_mclk);
			n++;
		end
		rc("pre-erase", dee_pkg::OFF_PEEK, 32'h0000_0000);
		wait_done();
		rc("ctrl end", dee_pkg::OFF_CTRL, 32'h0000_0000);
		rc("byte", dee_pkg::OFF_PEEK, 32'h0000_00A5);
		repeat (2) @(posedge i_mclk);
		chk("irq", 32'h0000_0001, {31'h0, o_nvm_irq});
		rc("done set", dee_pkg::OFF_DONE, 32'h0000_0007);
		chk("mf set", 32'h0000_0001, {31'h0, o_mf_flag});
		i_mf_service <= 1'b1;
		@(posedge i_mclk);
		i_mf_service <= 1'b0;
		repeat (2) @(posedge i_mclk);
		rc("mf serviced", dee_pkg::OFF_DONE, 32'h0000_0003);
		wr(dee_pkg::OFF_DONE, 8'h02);
		repeat (2) @(posedge i_mclk);
		chk("irq off", 32'h0000_0000, {31'h0, o_nvm_irq});
		slow = 1'b0;
		$display("test byte write finished");
	endtask : t_byte

	task automatic t_perase();
		wr(dee_pkg::OFF_ADDR, 8'h30);
		wr(dee_pkg::OFF_CTRL, 8'h10);
		repeat (16) wr(dee_pkg::OFF_DATA, 8'h5A);
		rc("addr sat", dee_pkg::OFF_ADDR, 32'h0000_003F);
		launch(8'h50, 8'h20);
		wait_done();
		rc("ctrl end", dee_pkg::OFF_CTRL, 32'h0000_0010);
		for (int i = 0; i < 16; i++) begin
			wr(dee_pkg::OFF_ADDR, 8'(8'h30 + i));
			rc("erased", dee_pkg::OFF_PEEK, 32'h0000_0000);
		end
		$display("test page erase finished");
	endtask : t_perase

	task automatic t_pwrite();
		wr(dee_pkg::OFF_ADDR, 8'h30);
		for (int i = 0; i < 17; i++) wr(dee_pkg::OFF_DATA, 8'(8'h10 + i));
		rc("addr sat", dee_pkg::OFF_ADDR, 32'h0000_003F);
		launch(8'h18, 8'h04);
		wait_done();
		rc("ctrl end", dee_pkg::OFF_CTRL, 32'h0000_0010);
		for (int i = 0; i < 16; i++) begin
			wr(dee_pkg::OFF_ADDR, 8'(8'h30 + i));
			rc("paged", dee_pkg::OFF_PEEK, 32'(8'h10 + i));
		end
		$display("test page write finished");
	endtask : t_pwrite

	// an enable that falls before start leaves nothing to act on
	task automatic t_bufclr(input logic [7:0] a, input logic [7:0] en, input logic [7:0] go);
		wr(dee_pkg::OFF_ADDR, a);
		wr(dee_pkg::OFF_DATA, 8'h00);
		wr(dee_pkg::OFF_CTRL, en);
		wr(dee_pkg::OFF_CTRL, 8'h10);
		launch(en, go);
		wait_done();
		wr(dee_pkg::OFF_ADDR, a);
		rc("kept", dee_pkg::OFF_PEEK, 32'(a - 8'h20));
		$display("test buffer clear finished");
	endtask : t_bufclr

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	initial begin
		{i_mclk, i_rstn, i_read, i_write, i_mf_service, slow} = 6'b000000;
		i_ce = 1'b1;
		global_irq_enable = 1'b1;
		i_byteenable = 4'hF;
		i_address = 5'h00;
		i_writedata = 32'h0000_0000;
		{n_fail, checked, cycles} = {32'd0, 32'd0, 32'd0};
		repeat (3) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(posedge i_mclk);
		t_reset();
		t_refuse();
		t_byte();
		t_perase();
		t_pwrite();
		t_bufclr(8'h30, 8'h50, 8'h20);
		t_bufclr(8'h31, 8'h18, 8'h04);
		end_sim();
	end
endmodule : dee_ctrl_test

`default_nettype wire
